/* File: shared/sfa_pkg.sv */
// shared constants, types and helpers for the spi frame access block
package sfa_pkg;

    // field widths of the frame header and data units
    localparam int ADDR_W  = 16;
    localparam int LEN_W   = 15;
    localparam int BYTE_W  = 8;

    // selector sits at the top of the third header byte
    localparam int SEL_POS = 7;

    // bit counter values inside one serial byte, msb first
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [2:0] BIT_STEP  = 3'h1;

    // header byte order
    localparam logic [1:0] HDR_ADDR_HI = 2'h0;
    localparam logic [1:0] HDR_ADDR_LO = 2'h1;
    localparam logic [1:0] HDR_SEL_LEN = 2'h2;
    localparam logic [1:0] HDR_LEN_LO  = 2'h3;
    localparam logic [1:0] HDR_STEP    = 2'h1;

    // selector encodings
    localparam logic SEL_READ  = 1'b0;
    localparam logic SEL_WRITE = 1'b1;

    // reset and step values
    localparam logic [LEN_W-1:0]  LEN_ZERO  = 15'h0000;
    localparam logic [LEN_W-1:0]  LEN_ONE   = 15'h0001;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;

    // frame parser phases, link side
    typedef enum logic [1:0] {SFA_HDR, SFA_DATA, SFA_DONE} sfa_phase_t;

    // core side access sequencer
    typedef enum logic [1:0] {SFA_CP_IDLE, SFA_CP_ISSUE, SFA_CP_TAKE} sfa_cp_state_t;

    // one access handed from the link to the core domain
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } sfa_req_t;

    localparam sfa_req_t REQ_RESET = '{wr: SEL_READ, addr: ADDR_ZERO, data: BYTE_ZERO};

    // next internal address of a burst
    function automatic logic [ADDR_W-1:0] sfa_next_addr(input logic [ADDR_W-1:0] a);
        return a + ADDR_STEP;
    endfunction : sfa_next_addr

endpackage : sfa_pkg

/* File: rtl/sfa_sync.sv */
// two flip-flop level synchroniser with asynchronous reset value
`timescale 1ns/100ps
`default_nettype none

module sfa_sync
#(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= RST;
            q      <= RST;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : sfa_sync

`default_nettype wire

/* File: rtl/sfa_core_port.sv */
// core side sequencer: turns link requests into internal memory accesses
`timescale 1ns/100ps
`default_nettype none

module sfa_core_port
    import sfa_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_tgl,
    input  wire sfa_req_t          req,
    input  wire logic [BYTE_W-1:0] mem_rdata,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic      [BYTE_W-1:0] mem_wdata,
    output logic                   mem_we,
    output logic                   mem_re,
    output logic      [BYTE_W-1:0] rd_data,
    output logic                   ack_tgl
);

    logic          req_s;
    logic          seen_q;
    logic          seen_d;
    sfa_cp_state_t state_q;
    sfa_cp_state_t state_d;
    logic [ADDR_W-1:0] addr_d;
    logic [BYTE_W-1:0] wdata_d;
    logic [BYTE_W-1:0] rdata_d;
    logic          we_d;
    logic          re_d;
    logic          ack_d;

    // request toggle comes from the serial clock domain
    sfa_sync #(.W(1), .RST(1'b0)) u_req_sync
    (
        .clk    (clk),
        .arst_n (rst_n),
        .d      (req_tgl),
        .q      (req_s)
    );

    // req fields are held stable by the link until the next toggle
    always_comb
    begin
        state_d = state_q;
        seen_d  = seen_q;
        addr_d  = mem_addr;
        wdata_d = mem_wdata;
        rdata_d = rd_data;
        we_d    = 1'b0;
        re_d    = 1'b0;
        ack_d   = ack_tgl;
        unique case (state_q)
            SFA_CP_IDLE:
            begin
                if (req_s != seen_q)
                begin
                    seen_d = req_s;
                    addr_d = req.addr;
                    if (req.wr == SEL_WRITE)
                    begin
                        wdata_d = req.data;       // RULE11
                        we_d    = 1'b1;           // RULE12
                        ack_d   = ~ack_tgl;
                    end
                    else
                    begin
                        re_d    = 1'b1;
                        state_d = SFA_CP_ISSUE;
                    end
                end
            end
            SFA_CP_ISSUE:
            begin
                // memory answers one cycle after the read strobe
                state_d = SFA_CP_TAKE;
            end
            SFA_CP_TAKE:
            begin
                rdata_d = mem_rdata;
                ack_d   = ~ack_tgl;
                state_d = SFA_CP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q   <= SFA_CP_IDLE;
            seen_q    <= 1'b0;
            mem_addr  <= ADDR_ZERO;
            mem_wdata <= BYTE_ZERO;
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
            rd_data   <= BYTE_ZERO;
            ack_tgl   <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            seen_q    <= seen_d;
            mem_addr  <= addr_d;
            mem_wdata <= wdata_d;
            mem_we    <= we_d;
            mem_re    <= re_d;
            rd_data   <= rdata_d;
            ack_tgl   <= ack_d;
        end
    end

endmodule : sfa_core_port

`default_nettype wire

/* File: rtl/sfa_frame_access.sv */
// spi slave frame parser giving a serial host access to internal memory
//
// Function
// RULE1: slave only, clock modes 0 and 3
// RULE2: sample on rising, shift out on falling
// RULE3: either clock idle level accepted
// RULE4: host sends header before data
// RULE5: header is address, selector, length
// RULE6: selector 0 reads, 1 writes
// RULE7: four header bytes, selector in bit 7
// RULE8: length one read returns one byte
// RULE9: burst read returns byte per dummy
// RULE10: host shifts dummy byte per read byte
// RULE11: length one write stores one byte
// RULE12: burst write stores every data byte
// RULE13: host sends write data after header
// RULE14: drive output low after select falls
// RULE15: host drives input low for writes
// RULE16: release output when select rises
// RULE17: host keeps select high when idle
// RULE18: host holds select low whole frame
// RULE19: burst address increments per byte
// RULE20: select rise abandons frame, back idle
// RULE21: zero length frame makes no access; a zero length read still issues one memory read
`timescale 1ns/100ps
`default_nettype none

module sfa_frame_access
    import sfa_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    output logic                   miso_o,
    output logic                   miso_oe,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic      [BYTE_W-1:0] mem_wdata,
    output logic                   mem_we,
    output logic                   mem_re,
    input  wire logic [BYTE_W-1:0] mem_rdata
);

    // ------------------------------------------------------------------
    // core domain: reset for the link toggles and the output enable
    // ------------------------------------------------------------------

    logic lrst_n_q;
    logic lrst_n_d;
    logic cs_s;
    logic oe_q;
    logic oe_d;

    // chip select enters the core domain through two flops
    sfa_sync #(.W(1), .RST(1'b1)) u_cs_sync
    (
        .clk    (core_clk),
        .arst_n (rst_n),
        .d      (cs_n),
        .q      (cs_s)
    );

    // output enable follows select; a few core cycles of lag, far below
    // the header length, so the line is low long before data is due
    always_comb
    begin
        lrst_n_d = rst_n;
        oe_d     = ~cs_s;                        // RULE14 RULE16
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            lrst_n_q <= 1'b0;
            oe_q     <= 1'b0;
        end
        else
        begin
            lrst_n_q <= lrst_n_d;
            oe_q     <= oe_d;
        end
    end

    assign miso_oe = oe_q;

    // ------------------------------------------------------------------
    // link domain, rising edge: header parse and request generation
    // every frame register is cleared while select is high, so a
    // partial header or burst can never leak into the next frame
    // ------------------------------------------------------------------

    logic [2:0]        bit_cnt_q;
    logic [2:0]        bit_cnt_d;
    logic [6:0]        shift_q;
    logic [6:0]        shift_d;
    logic [1:0]        hdr_idx_q;
    logic [1:0]        hdr_idx_d;
    sfa_phase_t        phase_q;
    sfa_phase_t        phase_d;
    logic              sel_q;
    logic              sel_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [LEN_W-1:0]  remain_q;
    logic [LEN_W-1:0]  remain_d;
    logic [LEN_W-1:0]  fetch_left_q;
    logic [LEN_W-1:0]  fetch_left_d;
    logic [BYTE_W-1:0] byte_in;
    logic [LEN_W-1:0]  len_full;

    // request channel survives select, so it lives under the link reset
    sfa_req_t          req_q;
    sfa_req_t          req_d;
    logic              req_tgl_q;
    logic              req_tgl_d;
    logic              ack_tgl;
    logic              ack_s;
    logic [BYTE_W-1:0] rd_data;

    always_comb
    begin
        bit_cnt_d    = bit_cnt_q + BIT_STEP;     // RULE2
        byte_in      = {shift_q, mosi};
        shift_d      = byte_in[6:0];
        hdr_idx_d    = hdr_idx_q;
        phase_d      = phase_q;
        sel_d        = sel_q;
        addr_d       = addr_q;
        remain_d     = remain_q;
        fetch_left_d = fetch_left_q;
        len_full     = {remain_q[LEN_W-1:BYTE_W], byte_in};
        req_d        = req_q;
        req_tgl_d    = req_tgl_q;
        unique case (phase_q)
            SFA_HDR:
            begin
                // fetch the first read byte as soon as the selector shows
                // a read; waiting for the length would leave only half a
                // serial clock before the first data bit is due
                if ((hdr_idx_q == HDR_SEL_LEN) && (bit_cnt_q == BIT_FIRST)
                    && (mosi == SEL_READ))
                begin
                    req_d     = '{wr: SEL_READ, addr: addr_q, data: BYTE_ZERO};
                    req_tgl_d = ~req_tgl_q;
                    addr_d    = sfa_next_addr(addr_q);    // RULE19
                end
                if (bit_cnt_q == BIT_LAST)
                begin
                    hdr_idx_d = hdr_idx_q + HDR_STEP;     // RULE7
                    unique case (hdr_idx_q)
                        HDR_ADDR_HI: addr_d[ADDR_W-1:BYTE_W] = byte_in; // RULE5
                        HDR_ADDR_LO: addr_d[BYTE_W-1:0]      = byte_in;
                        HDR_SEL_LEN:
                        begin
                            sel_d = byte_in[SEL_POS];             // RULE6
                            remain_d[LEN_W-1:BYTE_W] = byte_in[SEL_POS-1:0];
                        end
                        HDR_LEN_LO:
                        begin
                            remain_d = len_full;
                            if (len_full == LEN_ZERO)
                            begin
                                phase_d = SFA_DONE;               // RULE21
                            end
                            else
                            begin
                                phase_d      = SFA_DATA;          // RULE8 RULE11
                                fetch_left_d = len_full - LEN_ONE;
                            end
                        end
                    endcase
                end
            end
            SFA_DATA:
            begin
                // prefetch the next read byte while this one shifts out
                if ((sel_q == SEL_READ) && (bit_cnt_q == BIT_FIRST)
                    && (fetch_left_q != LEN_ZERO))
                begin
                    req_d        = '{wr: SEL_READ, addr: addr_q, data: BYTE_ZERO};
                    req_tgl_d    = ~req_tgl_q;                // RULE9
                    addr_d       = sfa_next_addr(addr_q);     // RULE19
                    fetch_left_d = fetch_left_q - LEN_ONE;
                end
                if (bit_cnt_q == BIT_LAST)
                begin
                    remain_d = remain_q - LEN_ONE;
                    if (remain_q == LEN_ONE)
                    begin
                        phase_d = SFA_DONE;                   // RULE8 RULE11
                    end
                    if (sel_q == SEL_WRITE)
                    begin
                        req_d     = '{wr: SEL_WRITE, addr: addr_q, data: byte_in};
                        req_tgl_d = ~req_tgl_q;               // RULE12
                        addr_d    = sfa_next_addr(addr_q);    // RULE19
                    end
                end
            end
            SFA_DONE:
            begin
                // surplus bytes after the count are ignored until select rises
                remain_d = LEN_ZERO;
            end
        endcase
    end

    // frame state, cleared by select high
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_cnt_q    <= BIT_FIRST;           // RULE20
            shift_q      <= '0;
            hdr_idx_q    <= HDR_ADDR_HI;
            phase_q      <= SFA_HDR;
            sel_q        <= SEL_READ;
            addr_q       <= ADDR_ZERO;
            remain_q     <= LEN_ZERO;
            fetch_left_q <= LEN_ZERO;
        end
        else
        begin
            bit_cnt_q    <= bit_cnt_d;
            shift_q      <= shift_d;
            hdr_idx_q    <= hdr_idx_d;
            phase_q      <= phase_d;
            sel_q        <= sel_d;
            addr_q       <= addr_d;
            remain_q     <= remain_d;
            fetch_left_q <= fetch_left_d;
        end
    end

    // request word and toggle, reset only with the whole block
    always_ff @(posedge sclk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            req_q     <= REQ_RESET;
            req_tgl_q <= 1'b0;
        end
        else
        begin
            req_q     <= req_d;
            req_tgl_q <= req_tgl_d;
        end
    end

    // ------------------------------------------------------------------
    // link domain, falling edge: serial output
    // output is picked by the bits already sampled, not by counting
    // falling edges, so the extra leading fall of mode 3 is harmless
    // ------------------------------------------------------------------

    logic [BYTE_W-1:0] tx_q;
    logic [BYTE_W-1:0] tx_d;
    logic              miso_q;
    logic              miso_d;
    logic              rd_ready;

    // acknowledge toggle returns from the core domain
    sfa_sync #(.W(1), .RST(1'b0)) u_ack_sync
    (
        .clk    (sclk),
        .arst_n (lrst_n_q),
        .d      (ack_tgl),
        .q      (ack_s)
    );

    // read word is only taken once the handshake has closed
    always_comb
    begin
        rd_ready = (ack_s == req_tgl_q);
        tx_d     = tx_q;
        if (bit_cnt_q == BIT_FIRST)
        begin
            if ((phase_q == SFA_DATA) && (sel_q == SEL_READ) && rd_ready)
            begin
                tx_d = rd_data;                  // RULE8 RULE9
            end
            else
            begin
                tx_d = BYTE_ZERO;                // RULE14
            end
        end
        miso_d = tx_d[~bit_cnt_q];               // RULE1 RULE2 RULE3
    end

    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            tx_q   <= BYTE_ZERO;
            miso_q <= 1'b0;                      // RULE14
        end
        else
        begin
            tx_q   <= tx_d;
            miso_q <= miso_d;
        end
    end

    assign miso_o = miso_q;

    // ------------------------------------------------------------------
    // core domain access port
    // ------------------------------------------------------------------

    sfa_core_port u_core_port
    (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .req_tgl   (req_tgl_q),
        .req       (req_q),
        .mem_rdata (mem_rdata),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_we    (mem_we),
        .mem_re    (mem_re),
        .rd_data   (rd_data),
        .ack_tgl   (ack_tgl)
    );

endmodule : sfa_frame_access

`default_nettype wire

/* File: testbench/sfa_frame_access_monitor.sv */
// assertion checker for the spi frame access block
`timescale 1ns/100ps
`default_nettype none

module sfa_frame_access_monitor
    import sfa_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    input  wire logic              miso_o,
    input  wire logic              miso_oe,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [BYTE_W-1:0] mem_wdata,
    input  wire logic              mem_we,
    input  wire logic              mem_re,
    input  wire logic [BYTE_W-1:0] mem_rdata
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic [ADDR_W-1:0] last_q;
    logic              seen_q;
    logic              cs_q;

    // previous access address, forgotten when a new frame opens
    always_ff @(posedge core_clk)
    begin
        cs_q   <= cs_n;
        seen_q <= rst_n && !(cs_q && !cs_n) && (seen_q || mem_we || mem_re);
        last_q <= (mem_we || mem_re) ? mem_addr : last_q;
    end

    // sync lag is three flops, one spare cycle for the async edge
    a_oe_on: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
        else $error("miso enable late after select fell");
    a_oe_off: assert property ($rose(cs_n) |-> ##[1:4] !miso_oe)
        else $error("miso enable kept after select rose");
    a_idle_low: assert property (cs_n |-> !miso_o)
        else $error("miso not low outside a frame");
    a_we_pulse: assert property (mem_we |=> (!mem_we) [*8])
        else $error("write strobe too long or too close");
    a_re_pulse: assert property (mem_re |=> (!mem_re) [*8])
        else $error("read strobe too long or too close");
    a_one_kind: assert property (!(mem_we && mem_re))
        else $error("read and write strobes together");
    a_burst_step: assert property ((mem_we || mem_re) && seen_q |-> mem_addr == last_q + ADDR_STEP)
        else $error("burst address did not step by one");
    a_access_framed: assert property ((mem_we || mem_re) |-> !$past(cs_n, 8))
        else $error("memory access without a frame");

    c_write: cover property (mem_we);
    c_read: cover property (mem_re);
    c_burst: cover property (mem_we && seen_q);
endmodule : sfa_frame_access_monitor

bind sfa_frame_access sfa_frame_access_monitor sfa_frame_access_monitor_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

`default_nettype wire

/* File: testbench/sfa_host_model.sv */
// serial host model: frames header and data, collects read bytes
`timescale 1ns/100ps
`default_nettype none

module sfa_host_model
(
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];

    // idle: deselected, clock parked
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // shift out on the fall, sample on the rise
    task automatic put_bit(input logic b, output logic r);
        sclk = 1'b0;
        mosi = b;
        #80;
        sclk = 1'b1;
        r = miso;
        #80;
    endtask : put_bit

    // cut drops that many trailing bits to abort a frame
    task automatic frame(input logic [31:0] hdr, input int nb, input int cut, input logic m3);
        logic [7:0] sr;
        logic [7:0] rs;
        logic       r;
        sclk = m3;
        #80;
        cs_n = 1'b0;
        mosi = 1'b0;
        #80;
        for (int i = 31; i >= 0; i--) put_bit(hdr[i], r);
        for (int i = 0; i < nb * 8 - cut; i++)
        begin
            if (i % 8 == 0) sr = tx_q.pop_front();
            put_bit(sr[7 - i % 8], r);
            rs = {rs[6:0], r};
            if (i % 8 == 7) rx_q.push_back(rs);
        end
        sclk = m3;
        #80;
        cs_n = 1'b1;
        mosi = ~mosi; // released line must not look like held data
        tx_q.delete();
    endtask : frame
endmodule : sfa_host_model

`default_nettype wire

/* File: testbench/sfa_frame_access_tb.sv */
// self-checking bench for the spi frame access block
`timescale 1ns/100ps
`default_nettype none

module sfa_frame_access_tb
    import sfa_pkg::*;
;
    logic              core_clk;
    logic              rst_n;
    logic              sclk;
    logic              cs_n;
    logic              mosi;
    logic              miso_o;
    logic              miso_oe;
    logic              miso_w;
    logic              tgl_q;
    logic [ADDR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_wdata;
    logic              mem_we;
    logic              mem_re;
    logic [BYTE_W-1:0] mem_rdata;
    logic [7:0]        mem [65536];
    logic [7:0]        ref_m [logic [15:0]];
    logic [23:0]       wq[$];
    logic [23:0]       e;
    logic [31:0]       seed = 32'h00000063;
    int                err_total = 0;
    int                checks_done = 0;

    sfa_frame_access sfa_frame_access_inst (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    sfa_host_model sfa_host_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // undriven miso toggles so stale data cannot pass
    assign miso_w = miso_oe ? miso_o : tgl_q;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] initv(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : initv

    function automatic logic [7:0] refv(input logic [15:0] a);
        return ref_m.exists(a) ? ref_m[a] : initv(a);
    endfunction : refv

    task automatic cmp_wr(input logic [23:0] ex, input logic [23:0] g);
        checks_done++;
        if (g !== ex)
        begin
            err_total++;
            $display("mismatch at %0t exp %h got %h", $time, ex, g);
        end
    endtask : cmp_wr

    task automatic cmp_rd(input logic [7:0] ex, input logic [7:0] g);
        cmp_wr({16'h0000, ex}, {16'h0000, g});
    endtask : cmp_rd

    task automatic results();
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // memory far side: data valid the cycle after the read strobe
    always @(negedge core_clk)
    begin
        tgl_q <= ~tgl_q;
        if (mem_re === 1'b1) mem_rdata <= mem[mem_addr];
        if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    end

    // every write strobe must match the next expected write; looked at
    // mid-cycle so the strobe and its address have settled
    always @(negedge core_clk)
    begin
        if (mem_we === 1'b1)
        begin
            e = (wq.size() != 0) ? wq.pop_front() : 'x;
            cmp_wr(e, {mem_addr, mem_wdata});
            cmp_rd(8'h01, {7'h00, miso_oe});
        end
    end

    // one frame; only whole bytes before an abort count
    task automatic run(input logic sel, input logic [15:0] a, input logic [14:0] n,
                       input int cut, input logic m3);
        int         full;
        logic [7:0] b;
        full = n - (cut + 7) / 8;
        for (int i = 0; i < n; i++)
        begin
            b = 8'(xs());
            sfa_host_model_inst.tx_q.push_back(b);
            if (sel && i < full)
            begin
                wq.push_back({a + 16'(i), b});
                ref_m[a + 16'(i)] = b;
            end
        end
        sfa_host_model_inst.frame({a, sel, n}, int'(n), cut, m3);
        repeat (10) @(negedge core_clk);
        cmp_rd(8'h00, {7'h00, miso_oe});
        cmp_wr(24'h000000, 24'(wq.size()));
        if (!sel)
            for (int i = 0; i < full; i++)
                cmp_rd(refv(a + 16'(i)), sfa_host_model_inst.rx_q[i]);
        sfa_host_model_inst.rx_q.delete();
    endtask : run

    initial
    begin
        logic [15:0] a;
        rst_n = 1'b0;
        tgl_q = 1'b0;
        mem_rdata = 8'h00;
        for (int i = 0; i < 65536; i++) mem[i] = initv(16'(i));
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        for (int m = 0; m < 2; m++)
        begin
            a = 16'(xs());
            run(1'b1, a, 15'h0001, 0, m[0]);
            run(1'b0, a, 15'h0001, 0, m[0]);
            run(1'b1, a, 15'h0005, 0, m[0]);
            run(1'b0, a - 16'h0001, 15'h0007, 0, m[0]);
            run(1'b1, a, 15'h0000, 0, m[0]);
            run(1'b1, a + 16'h0010, 15'h0002, 5, m[0]);
            run(1'b0, a, 15'h0003, 12, m[0]);
            run(1'b0, a + 16'h0010, 15'h0002, 0, m[0]);
        end
        run(1'b1, 16'h1200, 15'h0100, 0, 1'b0);
        run(1'b0, 16'h12fe, 15'h0003, 0, 1'b1);
        results();
    end

    // watchdog well beyond the roughly 48k cycles the tests take
    initial
    begin
        #900us;
        err_total++;
        results();
    end
endmodule : sfa_frame_access_tb

`default_nettype wire
